/* rtl/pcr_pkg.sv */
// shared constants and types for the channel one configuration registers
package pcr_pkg;
  // register indices on the register access port
  localparam logic [5:0]  ADDR_GENERAL_CFG   = 6'h11;
  localparam logic [5:0]  ADDR_SLOT12_FMT    = 6'h12;
  localparam logic [5:0]  ADDR_SLOT34_FMT    = 6'h13;
  localparam logic [5:0]  ADDR_DIRECT_CMD    = 6'h1E;
  // reset values
  localparam logic [15:0] RST_GENERAL_CFG    = 16'h0101;
  localparam logic [15:0] RST_SLOT_FMT       = 16'h0514;
  // writable bits per register, reserved bits read zero
  localparam logic [15:0] MASK_GENERAL_CFG   = 16'hBFF7;
  localparam logic [15:0] MASK_SLOT12_FMT    = 16'h1FFF;
  localparam logic [15:0] MASK_SLOT34_FMT    = 16'h0FFF;
  // direct command that ends the programming phase
  localparam logic [15:0] CMD_END_OF_PROGRAMMING_PHASE    = 16'h1111;
  // general config field positions, then the bootstrap bit of the slot 1/2 register
  localparam int          POS_ODD_CHECK      = 15;
  localparam int          POS_SYNC_AMP       = 13;
  localparam int          POS_PIN_ROLE       = 12;
  localparam int          POS_MON_LO         = 10;
  localparam int          POS_ILIM_LO        = 8;
  localparam int          POS_INIT_CAP       = 7;
  localparam int          POS_SLOTS_LO       = 4;
  localparam int          POS_RATE_LO        = 1;
  localparam int          POS_SYNC_MODE      = 0;
  localparam int          POS_BOOT_DIS       = 12;
  // slot format field positions inside a slot-pair register
  localparam int          POS_LOW_SLOT       = 0;
  localparam int          POS_HIGH_SLOT      = 6;
  localparam int          POS_CHECK_IN_SLOT  = 5;
  // data length and slot count decode limits
  localparam logic [4:0]  LEN_MIN            = 5'h08;
  localparam logic [4:0]  LEN_MAX            = 5'h1C;
  localparam logic [4:0]  LEN_DEFAULT        = 5'h14;
  localparam logic [2:0]  SLOTS_MIN          = 3'h1;
  localparam logic [2:0]  SLOTS_MAX          = 3'h6;
  localparam logic [2:0]  SLOTS_DEFAULT      = 3'h3;
  localparam int          NUM_SLOTS          = 4;

  typedef enum logic [1:0] {MON_OFF = 2'b00, MON_STANDARD = 2'b01, MON_SIMPLE = 2'b10} pcr_mon_t;
  typedef enum logic [1:0] {ILIM_19MA = 2'b00, ILIM_35MA = 2'b01, ILIM_45MA = 2'b10} pcr_ilim_t;
  typedef enum logic [1:0] {RATE_125K = 2'b00, RATE_189K = 2'b01, RATE_83K = 2'b10} pcr_rate_t;

  typedef struct packed {
    logic      sync_amplitude_select;
    logic      output_pin_role;
    pcr_mon_t  slot_monitor_select;
    pcr_ilim_t idle_current_limit;
    logic      init_capture_enable;
    logic [2:0] slot_count;
    pcr_rate_t line_rate_select;
    logic      synchronous_mode_enable;
    logic      bootstrap_disable;
  } pcr_cfg_t;

  typedef struct packed {
    logic       slot_check_type;
    logic [4:0] slot_data_length;
  } pcr_slot_t;
endpackage

/* rtl/pcr_ch1_cfg.sv */
// channel one configuration registers with decoded settings for the channel logic
`timescale 1ns/1ps
// Overview of operation
// - general config bit 15 makes the whole word odd parity; even writes refused
// - bit 13 picks sync step: 0 gives 2.5 V, 1 gives 3.5 V
// - bit 12 picks output pin role: 0 sensor data, 1 interrupt
// - bits 11:10 monitoring: 00/11 off, 01 standard, 10 simple
// - bits 9:8 idle current: 00 19 mA, 01/11 35 mA, 10 45 mA
// - bit 7 set stores sensor init data in its buffer
// - bits 6:4 give 1 to 6 slots; other codes mean 3
// - bits 2:1 rate: 00/11 125k, 01 189k, 10 83.3k
// - bit 0 clear gives async mode without sync pulses, set gives sync
// - slot 1/2 register bit 12 set disables the bootstrap circuit
// - per slot check bit: 0 CRC, 1 parity
// - per slot length 01000..11100 gives 8..28 bits, else 20
// - lower slot bits 5 and 4:0, higher slot bits 11 and 10:6
// - slot 1 format used for all slots if init capture, simple monitor, async
// - propagation never alters stored fields of the other slots
// - end of programming command locks writes until any reset
module pcr_ch1_cfg (
  input  wire logic                                 MCLK,
  input  wire logic                                 RST_N,
  input  wire logic                                 REG_WR,
  input  wire logic                                 REG_RD,
  input  wire logic [5:0]                           REG_ADDR,
  input  wire logic [15:0]                          REG_WDATA,
  output logic      [15:0]                          REG_RDATA,
  output logic                                      REG_PAR_ERR,
  output logic                                      PROGRAMMING_PHASE_PHASE,
  output pcr_pkg::pcr_cfg_t                         CH_CFG,
  output pcr_pkg::pcr_slot_t [pcr_pkg::NUM_SLOTS-1:0] SLOT_FMT
);
  import pcr_pkg::*;

  logic [15:0] cr1_r, cr1_nxt;
  logic [15:0] cr2_r, cr2_nxt;
  logic [15:0] cr3_r, cr3_nxt;
  logic        programming_phase_r, programming_phase_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        perr_r, perr_nxt;
  pcr_cfg_t    cfg_r, cfg_nxt;
  pcr_slot_t [NUM_SLOTS-1:0] fmt_r, fmt_nxt;
  pcr_slot_t [NUM_SLOTS-1:0] raw_fmt;
  logic        wr_cr1, wr_cr2, wr_cr3, wr_dcr;
  logic        parity_ok;
  logic        propagate;

  function automatic logic [4:0] decode_len(input logic [4:0] code);
    // codes in range are the bit count directly
    if (code >= LEN_MIN && code <= LEN_MAX) begin
      decode_len = code;
    end else begin
      decode_len = LEN_DEFAULT;
    end
  endfunction

  // write decode and lock
  always_comb begin
    parity_ok = ^REG_WDATA;
    wr_cr1    = REG_WR && programming_phase_r && (REG_ADDR == ADDR_GENERAL_CFG);
    wr_cr2    = REG_WR && programming_phase_r && (REG_ADDR == ADDR_SLOT12_FMT);
    wr_cr3    = REG_WR && programming_phase_r && (REG_ADDR == ADDR_SLOT34_FMT);
    wr_dcr    = REG_WR && (REG_ADDR == ADDR_DIRECT_CMD);
    cr1_nxt   = cr1_r;
    cr2_nxt   = cr2_r;
    cr3_nxt   = cr3_r;
    perr_nxt  = 1'b0;
    programming_phase_nxt  = programming_phase_r;
    if (wr_cr1 && parity_ok) begin
      cr1_nxt = REG_WDATA & MASK_GENERAL_CFG;
    end
    if (wr_cr1 && !parity_ok) begin
      perr_nxt = 1'b1;
    end
    // only host writes reach these, propagation leaves them alone
    if (wr_cr2) begin
      cr2_nxt = REG_WDATA & MASK_SLOT12_FMT;
    end
    if (wr_cr3) begin
      cr3_nxt = REG_WDATA & MASK_SLOT34_FMT;
    end
    // once cleared only a reset brings it back
    if (wr_dcr && REG_WDATA == CMD_END_OF_PROGRAMMING_PHASE) begin
      programming_phase_nxt = 1'b0;
    end
  end

  // readback; the command register is write only and reads zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_GENERAL_CFG: begin
          rdata_nxt = cr1_r;
        end
        ADDR_SLOT12_FMT: begin
          rdata_nxt = cr2_r;
        end
        ADDR_SLOT34_FMT: begin
          rdata_nxt = cr3_r;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  // slot format extraction, one entry per slot
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      localparam int LO = (g % 2 == 0) ? POS_LOW_SLOT : POS_HIGH_SLOT;
      logic [15:0] src;
      assign src = (g < 2) ? cr2_r : cr3_r;
      assign raw_fmt[g].slot_check_type  = src[LO + POS_CHECK_IN_SLOT];
      assign raw_fmt[g].slot_data_length = src[LO +: 5];
    end
  endgenerate

  // decoded settings for the channel logic
  always_comb begin
    propagate = cr1_r[POS_INIT_CAP]
             || (cr1_r[POS_MON_LO +: 2] == MON_SIMPLE)
             || !cr1_r[POS_SYNC_MODE];
    cfg_nxt.sync_amplitude_select   = cr1_r[POS_SYNC_AMP];
    cfg_nxt.output_pin_role         = cr1_r[POS_PIN_ROLE];
    case (cr1_r[POS_MON_LO +: 2])
      2'b01: begin
        cfg_nxt.slot_monitor_select = MON_STANDARD;
      end
      2'b10: begin
        cfg_nxt.slot_monitor_select = MON_SIMPLE;
      end
      default: begin
        cfg_nxt.slot_monitor_select = MON_OFF;
      end
    endcase
    case (cr1_r[POS_ILIM_LO +: 2])
      2'b00: begin
        cfg_nxt.idle_current_limit = ILIM_19MA;
      end
      2'b10: begin
        cfg_nxt.idle_current_limit = ILIM_45MA;
      end
      default: begin
        cfg_nxt.idle_current_limit = ILIM_35MA;
      end
    endcase
    cfg_nxt.init_capture_enable = cr1_r[POS_INIT_CAP];
    if (cr1_r[POS_SLOTS_LO +: 3] >= SLOTS_MIN && cr1_r[POS_SLOTS_LO +: 3] <= SLOTS_MAX) begin
      cfg_nxt.slot_count = cr1_r[POS_SLOTS_LO +: 3];
    end else begin
      cfg_nxt.slot_count = SLOTS_DEFAULT;
    end
    case (cr1_r[POS_RATE_LO +: 2])
      2'b01: begin
        cfg_nxt.line_rate_select = RATE_189K;
      end
      2'b10: begin
        cfg_nxt.line_rate_select = RATE_83K;
      end
      default: begin
        cfg_nxt.line_rate_select = RATE_125K;
      end
    endcase
    cfg_nxt.synchronous_mode_enable = cr1_r[POS_SYNC_MODE];
    cfg_nxt.bootstrap_disable       = cr2_r[POS_BOOT_DIS];
    for (int i = 0; i < NUM_SLOTS; i++) begin
      // host may leave other slots stale, so slot 1 is forced here
      fmt_nxt[i].slot_check_type  = propagate ? raw_fmt[0].slot_check_type
                                              : raw_fmt[i].slot_check_type;
      fmt_nxt[i].slot_data_length = decode_len(propagate ? raw_fmt[0].slot_data_length
                                                         : raw_fmt[i].slot_data_length);
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cr1_r   <= RST_GENERAL_CFG;
      cr2_r   <= RST_SLOT_FMT;
      cr3_r   <= RST_SLOT_FMT;
      programming_phase_r  <= 1'b1;
      rdata_r <= 16'h0000;
      perr_r  <= 1'b0;
      cfg_r   <= '0;
      fmt_r   <= '0;
    end else begin
      cr1_r   <= cr1_nxt;
      cr2_r   <= cr2_nxt;
      cr3_r   <= cr3_nxt;
      programming_phase_r  <= programming_phase_nxt;
      rdata_r <= rdata_nxt;
      perr_r  <= perr_nxt;
      cfg_r   <= cfg_nxt;
      fmt_r   <= fmt_nxt;
    end
  end

  assign REG_RDATA   = rdata_r;
  assign REG_PAR_ERR = perr_r;
  assign PROGRAMMING_PHASE_PHASE  = programming_phase_r;
  assign CH_CFG      = cfg_r;
  assign SLOT_FMT    = fmt_r;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  AST_PARITY_REFUSE: assert property (
    (wr_cr1 && !(^REG_WDATA)) |=> ($stable(cr1_r) && REG_PAR_ERR))
    else $error("even parity write changed general config");
  AST_PARITY_TAKE: assert property (
    (wr_cr1 && (^REG_WDATA)) |=> (cr1_r == ($past(REG_WDATA) & MASK_GENERAL_CFG)) && !REG_PAR_ERR)
    else $error("odd parity write not stored");
  AST_LOCKED: assert property (
    (!PROGRAMMING_PHASE_PHASE && REG_WR) |=> ($stable(cr1_r) && $stable(cr2_r) && $stable(cr3_r)))
    else $error("write accepted after end of programming");
  AST_EOP: assert property (
    (REG_WR && REG_ADDR == ADDR_DIRECT_CMD && REG_WDATA == CMD_END_OF_PROGRAMMING_PHASE) |=> !PROGRAMMING_PHASE_PHASE [*2])
    else $error("end of programming did not lock");
  AST_SLOTS_DEFAULT: assert property (
    (cr1_r[6:4] == 3'h0 || cr1_r[6:4] == 3'h7) |=> CH_CFG.slot_count == 3'h3)
    else $error("slot count default wrong");
  AST_RATE: assert property (
    (cr1_r[2:1] == 2'b11) |=> CH_CFG.line_rate_select == RATE_125K)
    else $error("rate code 11 not 125k");
  AST_PROPAGATE: assert property (
    propagate |=> (SLOT_FMT[3] == SLOT_FMT[0] && SLOT_FMT[2] == SLOT_FMT[0]
      && SLOT_FMT[1] == SLOT_FMT[0]))
    else $error("slot one format not propagated");
  AST_NO_WRITEBACK: assert property (
    (propagate && !REG_WR) |=> ($stable(cr2_r) && $stable(cr3_r)))
    else $error("propagation altered stored slot fields");
  AST_LEN: assert property (
    (!propagate && (cr3_r[10:6] < 5'h08 || cr3_r[10:6] > 5'h1C))
      |=> SLOT_FMT[3].slot_data_length == 5'h14)
    else $error("out of range length not 20 bits");

  // decode lags the stored word by one edge
  AST_SYNC_AMP: assert property (
    1'b1 |=> (CH_CFG.sync_amplitude_select == $past(cr1_r[POS_SYNC_AMP])))
    else $error("sync amplitude select not taken from bit 13");
  AST_PIN_ROLE: assert property (
    1'b1 |=> (CH_CFG.output_pin_role == $past(cr1_r[POS_PIN_ROLE])))
    else $error("output pin role not taken from bit 12");
  AST_MON_OFF: assert property (
    (cr1_r[POS_MON_LO +: 2] == 2'h0 || cr1_r[POS_MON_LO +: 2] == 2'h3)
      |=> (CH_CFG.slot_monitor_select == MON_OFF))
    else $error("monitoring not disabled for code 00 or 11");
  AST_MON_STANDARD: assert property (
    (cr1_r[POS_MON_LO +: 2] == 2'h1) |=> (CH_CFG.slot_monitor_select == MON_STANDARD))
    else $error("monitoring code 01 not standard");
  AST_MON_SIMPLE: assert property (
    (cr1_r[POS_MON_LO +: 2] == 2'h2) |=> (CH_CFG.slot_monitor_select == MON_SIMPLE))
    else $error("monitoring code 10 not simple");
  AST_ILIM_19: assert property (
    (cr1_r[POS_ILIM_LO +: 2] == 2'h0) |=> (CH_CFG.idle_current_limit == ILIM_19MA))
    else $error("current code 00 not 19 mA");
  AST_ILIM_35: assert property (
    (cr1_r[POS_ILIM_LO +: 2] == 2'h1 || cr1_r[POS_ILIM_LO +: 2] == 2'h3)
      |=> (CH_CFG.idle_current_limit == ILIM_35MA))
    else $error("current code 01 or 11 not 35 mA");
  AST_ILIM_45: assert property (
    (cr1_r[POS_ILIM_LO +: 2] == 2'h2) |=> (CH_CFG.idle_current_limit == ILIM_45MA))
    else $error("current code 10 not 45 mA");
  AST_INIT_CAP: assert property (
    1'b1 |=> (CH_CFG.init_capture_enable == $past(cr1_r[POS_INIT_CAP])))
    else $error("init capture enable not taken from bit 7");
  AST_SLOTS_PASS: assert property (
    (cr1_r[POS_SLOTS_LO +: 3] >= 3'h1 && cr1_r[POS_SLOTS_LO +: 3] <= 3'h6)
      |=> (CH_CFG.slot_count == $past(cr1_r[POS_SLOTS_LO +: 3])))
    else $error("legal slot count not passed through");
  AST_RATE_125: assert property (
    (cr1_r[POS_RATE_LO +: 2] == 2'h0) |=> (CH_CFG.line_rate_select == RATE_125K))
    else $error("rate code 00 not 125k");
  AST_RATE_189: assert property (
    (cr1_r[POS_RATE_LO +: 2] == 2'h1) |=> (CH_CFG.line_rate_select == RATE_189K))
    else $error("rate code 01 not 189k");
  AST_RATE_83: assert property (
    (cr1_r[POS_RATE_LO +: 2] == 2'h2) |=> (CH_CFG.line_rate_select == RATE_83K))
    else $error("rate code 10 not 83.3k");
  AST_SYNC_MODE: assert property (
    1'b1 |=> (CH_CFG.synchronous_mode_enable == $past(cr1_r[POS_SYNC_MODE])))
    else $error("sync mode not taken from bit 0");
  AST_BOOT_DIS: assert property (
    1'b1 |=> (CH_CFG.bootstrap_disable == $past(cr2_r[POS_BOOT_DIS])))
    else $error("bootstrap disable not taken from slot 1/2 bit 12");
  AST_CHECK_TYPE: assert property (
    !propagate |=> (SLOT_FMT[1].slot_check_type == $past(cr2_r[11])
      && SLOT_FMT[2].slot_check_type == $past(cr3_r[5])))
    else $error("slot check type taken from wrong bit");
  AST_LEN_PASS: assert property (
    (!propagate && cr2_r[10:6] >= 5'h08 && cr2_r[10:6] <= 5'h1C)
      |=> (SLOT_FMT[1].slot_data_length == $past(cr2_r[10:6])))
    else $error("legal slot 2 length not passed through");
  AST_SLOT1_LEN: assert property (
    (cr2_r[4:0] >= 5'h08 && cr2_r[4:0] <= 5'h1C)
      |=> (SLOT_FMT[0].slot_data_length == $past(cr2_r[4:0])))
    else $error("slot 1 length not taken from bits 4:0");
  AST_READBACK: assert property (
    (REG_RD && REG_ADDR == ADDR_SLOT34_FMT) |=> (REG_RDATA == $past(cr3_r)))
    else $error("readback differs from stored slot 3/4 word");
  AST_LOCK_HOLDS: assert property (
    !PROGRAMMING_PHASE_PHASE |=> !PROGRAMMING_PHASE_PHASE)
    else $error("write access returned without reset");
  AST_OPEN_WRITE: assert property (
    (PROGRAMMING_PHASE_PHASE && REG_WR && REG_ADDR == ADDR_SLOT12_FMT)
      |=> (cr2_r == ($past(REG_WDATA) & MASK_SLOT12_FMT)))
    else $error("write in programming phase not stored");
endmodule

/* test/pcr_host_model.sv */
// host controller model driving the register access port
`timescale 1ns/1ps
module pcr_host_model (
  input  wire logic        MCLK,
  input  wire logic [15:0] REG_RDATA,
  output logic             REG_WR,
  output logic             REG_RD,
  output logic [5:0]       REG_ADDR,
  output logic [15:0]      REG_WDATA
);
  import pcr_pkg::*;
  initial begin
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_ADDR  = 6'h00;
    REG_WDATA = 16'h0000;
  end
  // released data toggles so a stale word never passes for a write
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge MCLK);
    REG_WR    = 1'b1;
    REG_ADDR  = a;
    REG_WDATA = d;
    @(negedge MCLK);
    REG_WR    = 1'b0;
    REG_WDATA = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] q);
    @(negedge MCLK);
    REG_RD   = 1'b1;
    REG_ADDR = a;
    @(negedge MCLK);
    REG_RD   = 1'b0;
    q        = REG_RDATA;
  endtask
  task automatic lock();
    wr(ADDR_DIRECT_CMD, CMD_END_OF_PROGRAMMING_PHASE);
  endtask
  // keeps readback of slots 2..4 in step with slot 1
  task automatic copy_slot1(input logic [5:0] f);
    wr(ADDR_SLOT12_FMT, {4'h0, f, f});
    wr(ADDR_SLOT34_FMT, {4'h0, f, f});
  endtask
endmodule

/* test/test_pcr_ch1_cfg.sv */
// self-checking bench for the channel one configuration registers
`timescale 1ns/1ps
module test_pcr_ch1_cfg;
  import pcr_pkg::*;
  logic            MCLK = 1'b0;
  logic            RST_N = 1'b0;
  logic            REG_WR, REG_RD, REG_PAR_ERR, PROGRAMMING_PHASE_PHASE;
  logic [5:0]      REG_ADDR;
  logic [15:0]     REG_WDATA, REG_RDATA, g;
  pcr_cfg_t        CH_CFG;
  pcr_slot_t [3:0] SLOT_FMT;
  int              mismatches = 0, comparisons = 0, perr = 0, cycles = 0;
  always #12.5 MCLK = ~MCLK;
  pcr_ch1_cfg pcr_ch1_cfg_inst (.MCLK(MCLK), .RST_N(RST_N), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_PAR_ERR(REG_PAR_ERR), .PROGRAMMING_PHASE_PHASE(PROGRAMMING_PHASE_PHASE), .CH_CFG(CH_CFG), .SLOT_FMT(SLOT_FMT));
  pcr_host_model pcr_host_model_inst (.MCLK(MCLK), .REG_RDATA(REG_RDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // run needs about 126 cycles
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (REG_PAR_ERR === 1'b1)
      perr <= perr + 1;
    if (cycles == 2000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic reg_chk(input logic [5:0] a, input logic [15:0] want);
    logic [15:0] q;
    pcr_host_model_inst.rd(a, q);
    check(q, want);
  endtask
  // odd parity word, then settle two edges for the decode
  task automatic wg(input logic [14:0] v);
    g = {~^v, v};
    pcr_host_model_inst.wr(ADDR_GENERAL_CFG, g);
    repeat (2) @(negedge MCLK);
  endtask
  function automatic pcr_cfg_t ecfg(input logic [15:0] w, input logic bt);
    pcr_cfg_t c;
    c.sync_amplitude_select   = w[13];
    c.output_pin_role         = w[12];
    c.slot_monitor_select     = (w[11:10] == 2'h3) ? MON_OFF : pcr_mon_t'(w[11:10]);
    c.idle_current_limit      = (w[9:8] == 2'h3) ? ILIM_35MA : pcr_ilim_t'(w[9:8]);
    c.init_capture_enable     = w[7];
    c.slot_count              = (w[6:4] == 3'h0 || w[6:4] == 3'h7) ? 3'h3 : w[6:4];
    c.line_rate_select        = (w[2:1] == 2'h3) ? RATE_125K : pcr_rate_t'(w[2:1]);
    c.synchronous_mode_enable = w[0];
    c.bootstrap_disable       = bt;
    return c;
  endfunction
  function automatic pcr_slot_t eslot(input logic [5:0] f);
    return {f[5], (f[4:0] >= 5'h08 && f[4:0] <= 5'h1C) ? f[4:0] : 5'h14};
  endfunction
  initial begin
    repeat (4) @(negedge MCLK);
    RST_N = 1'b1;
    @(negedge MCLK);
    reg_chk(ADDR_GENERAL_CFG, 16'h0101);
    reg_chk(ADDR_SLOT12_FMT, 16'h0514);
    reg_chk(ADDR_SLOT34_FMT, 16'h0514);
    check(CH_CFG, ecfg(16'h0101, 1'b0));
    check(SLOT_FMT, {4{eslot(6'h14)}});
    pcr_host_model_inst.wr(ADDR_GENERAL_CFG, 16'h0003);
    repeat (2) @(negedge MCLK);
    check(perr, 1);
    reg_chk(ADDR_GENERAL_CFG, 16'h0101);
    // reserved bits 14 and 3 written high, must read back low
    for (int i = 0; i < 8; i++) begin
      wg({1'b1, i[0], i[1], i[1:0], ~i[1:0], 1'b0, i[2:0], 1'b1, i[1:0], 1'b1});
      check(CH_CFG, ecfg(g, 1'b0));
      reg_chk(ADDR_GENERAL_CFG, g & MASK_GENERAL_CFG);
    end
    wg(15'h0411);
    pcr_host_model_inst.wr(ADDR_SLOT12_FMT, 16'h1A1C);
    pcr_host_model_inst.wr(ADDR_SLOT34_FMT, 16'h11FD);
    repeat (2) @(negedge MCLK);
    check(SLOT_FMT, {eslot(6'h07), eslot(6'h3D), eslot(6'h28), eslot(6'h1C)});
    check(CH_CFG.bootstrap_disable, 1'b1);
    reg_chk(ADDR_SLOT34_FMT, 16'h01FD);
    // init capture, simple monitoring, async mode
    for (int k = 0; k < 3; k++) begin
      wg((k == 0) ? 15'h0491 : (k == 1) ? 15'h0811 : 15'h0410);
      check(CH_CFG, ecfg(g, 1'b1));
      check(SLOT_FMT, {4{eslot(6'h1C)}});
      reg_chk(ADDR_SLOT34_FMT, 16'h01FD);
    end
    pcr_host_model_inst.copy_slot1(6'h1C);
    repeat (2) @(negedge MCLK);
    check(SLOT_FMT, {4{eslot(6'h1C)}});
    reg_chk(ADDR_SLOT34_FMT, 16'h071C);
    pcr_host_model_inst.lock();
    check(PROGRAMMING_PHASE_PHASE, 1'b0);
    pcr_host_model_inst.wr(ADDR_SLOT12_FMT, 16'h0208);
    wg(15'h0001);
    reg_chk(ADDR_SLOT12_FMT, 16'h071C);
    reg_chk(ADDR_GENERAL_CFG, 16'h8410);
    reg_chk(ADDR_DIRECT_CMD, 16'h0000);
    reg_chk(6'h20, 16'h0000);
    // a second reset reopens the programming phase
    RST_N = 1'b0;
    repeat (2) @(negedge MCLK);
    RST_N = 1'b1;
    @(negedge MCLK);
    check(PROGRAMMING_PHASE_PHASE, 1'b1);
    pcr_host_model_inst.wr(ADDR_SLOT12_FMT, 16'h0208);
    reg_chk(ADDR_SLOT12_FMT, 16'h0208);
    print_verdict();
  end
endmodule
